// File: core/cmx_exec.v
`timescale 1ns/1ps
`default_nettype none
`include "cmx_consts.vh"

// executes the or / move / store / literal / idle subset in a four-phase cycle
module cmx_exec #(
    parameter DATA_W = 8,
    parameter ADDR_W = 7,
    parameter DEPTH = 128
) (
    input wire sys_clk,
    input wire reset,
    input wire instr_valid,
    input wire [`CMX_IW_WIDTH-1:0] instr_word,
    output wire instr_ready,
    output reg [DATA_W-1:0] work_reg_ff,
    output reg zero_flag_ff,
    output reg pc_advance_ff,
    output reg unsupported_ff,
    output reg file_wr_en_ff,
    output reg [ADDR_W-1:0] file_wr_addr_ff,
    output reg [DATA_W-1:0] file_wr_data_ff,
    input wire [ADDR_W-1:0] peek_addr,
    output wire [DATA_W-1:0] peek_data
);

    localparam PH_DECODE = `CMX_PH_DECODE;
    localparam PH_READ = `CMX_PH_READ;
    localparam PH_EXEC = `CMX_PH_EXEC;
    localparam PH_WRITE = `CMX_PH_WRITE;

    // instruction cycle state
    reg [3:0] phase_ff;
    reg [3:0] nxt_phase;
    reg [`CMX_IW_WIDTH-1:0] instr_ff;
    reg [DATA_W-1:0] result_ff;
    reg [DATA_W-1:0] nxt_result;

    // decoded class of the latched word
    reg is_or_ff;
    reg is_move_ff;
    reg is_store_ff;
    reg is_lit_ff;
    reg is_idle_ff;

    // operand fields, decode and steering
    wire [DATA_W-1:0] file_rd_data;
    wire [ADDR_W-1:0] f_addr;
    wire dest_sel;
    wire [DATA_W-1:0] literal;
    wire dec_or;
    wire dec_move;
    wire dec_store;
    wire dec_lit;
    wire dec_idle;
    wire wr_file;
    wire wr_work;
    wire upd_zero;
    wire is_known;

    // operand fields of the latched word
    assign f_addr = instr_ff[`CMX_FADDR_MSB:0]; // RQ1 RQ3 RQ7
    assign dest_sel = instr_ff[`CMX_DEST_BIT];
    // only the low byte is the literal; bits 9:8 are don't-cares
    assign literal = instr_ff[`CMX_LIT_MSB:0]; // RQ9

    // opcode decode on the incoming word
    assign dec_or = (instr_word & `CMX_OR_WORK_INTO_FILE_MASK) == `CMX_OR_WORK_INTO_FILE_VAL;
    assign dec_move = (instr_word & `CMX_MOVE_FILE_REG_MASK) == `CMX_MOVE_FILE_REG_VAL;
    assign dec_store = (instr_word & `CMX_STORE_WORK_TO_FILE_MASK) == `CMX_STORE_WORK_TO_FILE_VAL;
    assign dec_lit = (instr_word & `CMX_LOAD_LITERAL_WORK_MASK) == `CMX_LOAD_LITERAL_WORK_VAL; // RQ9
    assign dec_idle = (instr_word & `CMX_IDLE_INSTRUCTION_MASK) == `CMX_IDLE_INSTRUCTION_VAL;

    // a new word is taken only at the start of an instruction cycle
    assign instr_ready = (phase_ff == PH_DECODE);

    // destination steering for the write phase
    assign wr_file = is_store_ff | ((is_or_ff | is_move_ff) & (dest_sel == `CMX_DEST_FILE)); // RQ2 RQ5 RQ7
    assign wr_work = is_lit_ff | ((is_or_ff | is_move_ff) & (dest_sel == `CMX_DEST_WORK)); // RQ2 RQ4 RQ8
    // only or and move touch the zero flag
    assign upd_zero = is_or_ff | is_move_ff; // RQ1 RQ6 RQ7 RQ8

    // a word outside the five classes still runs a full cycle, as idle
    assign is_known = is_or_ff | is_move_ff | is_store_ff | is_lit_ff | is_idle_ff;

    cmx_file_ram #(
        .DATA_W(DATA_W),
        .ADDR_W(ADDR_W),
        .DEPTH(DEPTH)
    ) u_file_ram (
        .sys_clk(sys_clk),
        .wr_en(file_wr_en_ff),
        .wr_addr(file_wr_addr_ff),
        .wr_data(file_wr_data_ff),
        .rd_addr(f_addr),
        .rd_data(file_rd_data),
        .peek_addr(peek_addr),
        .peek_data(peek_data)
    );

    // phase sequencer: waits in decode until a word arrives
    always @* begin
        case (phase_ff)
            PH_DECODE: begin
                if (instr_valid) begin
                    nxt_phase = PH_READ;
                end else begin
                    nxt_phase = PH_DECODE;
                end
            end
            PH_READ: begin
                nxt_phase = PH_EXEC;
            end
            PH_EXEC: begin
                nxt_phase = PH_WRITE;
            end
            PH_WRITE: begin
                nxt_phase = PH_DECODE; // RQ11
            end
            default: begin
                nxt_phase = PH_DECODE;
            end
        endcase
    end

    // result of the operation, formed in the execute phase
    always @* begin
        nxt_result = result_ff;
        if (phase_ff == PH_EXEC) begin
            if (is_or_ff) begin
                nxt_result = work_reg_ff | file_rd_data; // RQ1
            end else if (is_move_ff) begin
                nxt_result = file_rd_data; // RQ3
            end else if (is_store_ff) begin
                nxt_result = work_reg_ff; // RQ7
            end else if (is_lit_ff) begin
                nxt_result = literal; // RQ8
            end else begin
                nxt_result = result_ff;
            end
        end
    end

    // phase register and operation result
    always @(posedge sys_clk) begin
        if (reset) begin
            phase_ff <= PH_DECODE;
            result_ff <= {DATA_W{1'b0}};
        end else begin
            phase_ff <= nxt_phase;
            result_ff <= nxt_result;
        end
    end

    // latched word and decoded class, taken only on an accepted offer
    always @(posedge sys_clk) begin
        if (reset) begin
            instr_ff <= {`CMX_IW_WIDTH{1'b0}};
            is_or_ff <= 1'b0;
            is_move_ff <= 1'b0;
            is_store_ff <= 1'b0;
            is_lit_ff <= 1'b0;
            is_idle_ff <= 1'b0;
        end else if (instr_ready && instr_valid) begin
            instr_ff <= instr_word;
            is_or_ff <= dec_or;
            is_move_ff <= dec_move;
            is_store_ff <= dec_store;
            is_lit_ff <= dec_lit;
            is_idle_ff <= dec_idle; // RQ10
        end
    end

    // write phase: working register and zero flag
    always @(posedge sys_clk) begin
        if (reset) begin
            work_reg_ff <= `CMX_WORK_RST;
            zero_flag_ff <= `CMX_ZERO_RST;
        end else if (phase_ff == PH_WRITE) begin
            if (wr_work) begin
                work_reg_ff <= result_ff; // RQ2 RQ4 RQ8
            end
            if (upd_zero) begin
                zero_flag_ff <= (result_ff == {DATA_W{1'b0}}); // RQ1 RQ6
            end
        end
    end

    // write phase: file write request, a one-cycle pulse; address and data hold after it
    always @(posedge sys_clk) begin
        if (reset) begin
            file_wr_en_ff <= 1'b0;
            file_wr_addr_ff <= {ADDR_W{1'b0}};
            file_wr_data_ff <= {DATA_W{1'b0}};
        end else begin
            file_wr_en_ff <= 1'b0;
            if (phase_ff == PH_WRITE && wr_file) begin
                file_wr_en_ff <= 1'b1; // RQ2 RQ5 RQ7
                file_wr_addr_ff <= f_addr;
                file_wr_data_ff <= result_ff;
            end
        end
    end

    // end-of-cycle strobes: counter advance for every word, flag for unknown ones
    always @(posedge sys_clk) begin
        if (reset) begin
            pc_advance_ff <= 1'b0;
            unsupported_ff <= 1'b0;
        end else if (phase_ff == PH_WRITE) begin
            pc_advance_ff <= 1'b1; // RQ10 RQ11
            unsupported_ff <= !is_known;
        end else begin
            pc_advance_ff <= 1'b0;
            unsupported_ff <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: core/cmx_file_ram.v
`timescale 1ns/1ps
`default_nettype none

// file register store: one write port, two registered read ports
module cmx_file_ram #(
    parameter DATA_W = 8,
    parameter ADDR_W = 7,
    parameter DEPTH = 128
) (
    input wire sys_clk,
    input wire wr_en,
    input wire [ADDR_W-1:0] wr_addr,
    input wire [DATA_W-1:0] wr_data,
    input wire [ADDR_W-1:0] rd_addr,
    output reg [DATA_W-1:0] rd_data,
    input wire [ADDR_W-1:0] peek_addr,
    output reg [DATA_W-1:0] peek_data
);

    reg [DATA_W-1:0] mem [0:DEPTH-1];

    // read first, reads return the old contents
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
        peek_data <= mem[peek_addr];
    end

endmodule

`default_nettype wire

// File: pkg/cmx_consts.vh
// Functional notes
// RQ1: or_work_into_file ORs the working register with file register f (0..127) and updates the zero flag.
// RQ2: for or_work_into_file a destination select of 0 writes the working register, 1 writes file register f.
// RQ3: move_file_reg copies file register f (0..127) to the destination picked by the one-bit select.
// RQ4: move_file_reg with select 0 loads the working register and leaves the file register alone.
// RQ5: move_file_reg with select 1 writes the same value back into file register f.
// RQ6: move_file_reg sets the zero flag when the moved value is zero and clears it otherwise, for both selects.
// RQ7: store_work_to_file writes the working register into file register f (0..127) and touches no flag.
// RQ8: load_literal_work puts its 8-bit literal (0..255) into the working register and touches no flag.
// RQ9: the don't-care bits of load_literal_work are zeros when assembled and are ignored by the decoder.
// RQ10: idle_instruction changes no register, no file location and no flag; it only advances the counter.
// RQ11: each of the five instructions is one word and completes in one instruction cycle of four phases.
`ifndef CMX_CONSTS_VH
`define CMX_CONSTS_VH

// instruction word and operand fields
`define CMX_IW_WIDTH 14
`define CMX_FADDR_MSB 6
`define CMX_DEST_BIT 7
`define CMX_LIT_MSB 7

// opcode match masks and values
`define CMX_OR_WORK_INTO_FILE_MASK 14'h3F00
`define CMX_OR_WORK_INTO_FILE_VAL 14'h0400
`define CMX_MOVE_FILE_REG_MASK 14'h3F00
`define CMX_MOVE_FILE_REG_VAL 14'h0800
`define CMX_STORE_WORK_TO_FILE_MASK 14'h3F80
`define CMX_STORE_WORK_TO_FILE_VAL 14'h0080
`define CMX_LOAD_LITERAL_WORK_MASK 14'h3C00
`define CMX_LOAD_LITERAL_WORK_VAL 14'h3000
`define CMX_IDLE_INSTRUCTION_MASK 14'h3F9F
`define CMX_IDLE_INSTRUCTION_VAL 14'h0000

// destination select values
`define CMX_DEST_WORK 1'b0
`define CMX_DEST_FILE 1'b1

// instruction cycle phases, one-hot
`define CMX_PH_DECODE 4'h1
`define CMX_PH_READ 4'h2
`define CMX_PH_EXEC 4'h4
`define CMX_PH_WRITE 4'h8

// reset values
`define CMX_WORK_RST 8'h00
`define CMX_ZERO_RST 1'b0

`endif

// File: tb/cmx_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cmx_exec_bench;
    logic sys_clk, reset, instr_valid, z;
    logic [13:0] instr_word;
    logic [6:0] peek_addr;
    logic [7:0] w;
    logic [7:0] mem [0:127];
    logic [31:0] seed;
    int error_cnt, tests_run, cyc = 0;
    wire logic instr_ready, zero_flag_ff, pc_advance_ff, unsupported_ff, file_wr_en_ff;
    wire logic [7:0] work_reg_ff, file_wr_data_ff, peek_data;
    wire logic [6:0] file_wr_addr_ff;
    cmx_exec dut_u (.sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .work_reg_ff(work_reg_ff), .zero_flag_ff(zero_flag_ff),
        .pc_advance_ff(pc_advance_ff), .unsupported_ff(unsupported_ff), .file_wr_en_ff(file_wr_en_ff),
        .file_wr_addr_ff(file_wr_addr_ff), .file_wr_data_ff(file_wr_data_ff),
        .peek_addr(peek_addr), .peek_data(peek_data));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    function [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction
    // result value of one instruction
    function [7:0] calc(input [13:0] wd, input [7:0] wv, input [7:0] fv);
        if (wd[13:12] == 2'h3) calc = wd[7:0];
        else if (wd[11]) calc = fv;
        else if (wd[10]) calc = wv | fv;
        else calc = wv;
    endfunction
    task chk(input logic ok, input string m);
        tests_run++;
        if (!ok) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task close_out;
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // update the model, offer one word, compare after the cycle ends
    task run(input [13:0] wd);
        logic [7:0] r;
        logic unk;
        // a word outside the five encodings runs as idle and raises the unsupported strobe
        unk = !(wd[13:8] == 6'h04 || wd[13:8] == 6'h08 || wd[13:7] == 7'h01 || wd[13:10] == 4'hC
            || (wd[13:7] == 7'h00 && wd[4:0] == 5'h00));
        r = calc(wd, w, mem[wd[6:0]]);
        if (!unk && (wd[13:12] == 2'h3 || (wd[13:8] != 6'h00 && !wd[7]))) w = r;
        else if (!unk && (wd[13:8] != 6'h00 || wd[7])) mem[wd[6:0]] = r;
        if (wd[13:8] == 6'h04 || wd[13:8] == 6'h08) z = (r == 8'h00);
        @(posedge sys_clk) #1;
        instr_valid = 1'b1;
        instr_word = wd;
        while (instr_ready !== 1'b1) @(posedge sys_clk) #1;
        @(posedge sys_clk) #1 instr_valid = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk(pc_advance_ff === 1'b1 && unsupported_ff === unk, "advance");
        chk(work_reg_ff === w && zero_flag_ff === z, "work or zero");
    endtask
    initial begin
        reset = 1'b1;
        instr_valid = 1'b0;
        instr_word = 14'h0000;
        peek_addr = 7'h00;
        seed = 32'h00004263;
        w = 8'h00;
        z = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 reset = 1'b0;
        chk(work_reg_ff === 8'h00 && zero_flag_ff === 1'b0 && instr_ready === 1'b1, "reset state");
        // fill every file register, zeros among them
        for (int a = 0; a < 128; a++) begin
            seed = xs(seed);
            run({6'h30, seed[3] ? 8'h00 : seed[7:0]});
            run({7'h01, a[6:0]});
        end
        for (int i = 0; i < 600; i++) begin
            seed = xs(seed);
            case (seed[10:8])
                3'h0, 3'h1: run({6'h04, seed[7:0]});
                3'h2, 3'h3: run({6'h08, seed[7:0]});
                3'h4: run({7'h01, seed[6:0]});
                3'h5: run({4'hC, seed[13:12], seed[4] ? 8'h00 : seed[7:0]});
                3'h6: run({7'h00, seed[6:5], 5'h00});
                default: run({7'h11, seed[6:0]});
            endcase
        end
        // words outside the subset leave all state alone and flag themselves
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            run({6'h01, seed[7:0]});
            run({7'h00, seed[9:8], seed[4:0] | 5'h01});
        end
        // file contents through the read-back port
        for (int a = 0; a < 128; a++) begin
            @(posedge sys_clk) #1 peek_addr = a[6:0];
            @(posedge sys_clk) #1 chk(peek_data === mem[a], "file contents");
        end
        close_out;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out;
        end
    end
endmodule
`default_nettype wire

// File: tb/cmx_exec_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cmx_exec_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic instr_ready,
    input wire logic [7:0] work_reg_ff,
    input wire logic zero_flag_ff,
    input wire logic pc_advance_ff,
    input wire logic file_wr_en_ff,
    input wire logic [6:0] file_wr_addr_ff,
    input wire logic [7:0] file_wr_data_ff
);
    // accepted word and its class
    wire logic tk = instr_valid && instr_ready;
    wire logic op_fd = tk && (instr_word[13:8] == 6'h04 || instr_word[13:8] == 6'h08);
    wire logic op_lit = tk && instr_word[13:10] == 4'hC;
    wire logic op_st = tk && instr_word[13:7] == 7'h01;
    wire logic op_idle = tk && instr_word[13:7] == 7'h00 && instr_word[4:0] == 5'h00;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_gap; tk |=> !instr_ready [*3] ##1 instr_ready; endproperty
    a_gap: assert property (p_gap) else $error("ready gap wrong");
    property p_adv; tk |-> ##4 pc_advance_ff; endproperty
    a_adv: assert property (p_adv) else $error("no advance pulse");
    property p_pulse; pc_advance_ff |=> !pc_advance_ff; endproperty
    a_pulse: assert property (p_pulse) else $error("advance too long");
    property p_dst; op_fd |-> ##4 file_wr_en_ff == $past(instr_word[7], 4)
        && (!file_wr_en_ff || file_wr_addr_ff == $past(instr_word[6:0], 4)); endproperty
    a_dst: assert property (p_dst) else $error("wrong destination");
    property p_zf; op_fd |-> ##4
        zero_flag_ff == (($past(instr_word[7], 4) ? file_wr_data_ff : work_reg_ff) == 8'h00); endproperty
    a_zf: assert property (p_zf) else $error("zero flag wrong");
    property p_st; op_st |-> ##4 file_wr_en_ff && file_wr_addr_ff == $past(instr_word[6:0], 4)
        && file_wr_data_ff == work_reg_ff && zero_flag_ff == $past(zero_flag_ff, 4); endproperty
    a_st: assert property (p_st) else $error("store wrong");
    property p_lit; op_lit |-> ##4 work_reg_ff == $past(instr_word[7:0], 4)
        && zero_flag_ff == $past(zero_flag_ff, 4) && !file_wr_en_ff; endproperty
    a_lit: assert property (p_lit) else $error("literal wrong");
    property p_idle; op_idle |-> ##4 !file_wr_en_ff && work_reg_ff == $past(work_reg_ff, 4)
        && zero_flag_ff == $past(zero_flag_ff, 4); endproperty
    a_idle: assert property (p_idle) else $error("idle changed state");
endmodule
bind cmx_exec cmx_exec_chk chk_u (.sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .work_reg_ff(work_reg_ff),
    .zero_flag_ff(zero_flag_ff), .pc_advance_ff(pc_advance_ff), .file_wr_en_ff(file_wr_en_ff),
    .file_wr_addr_ff(file_wr_addr_ff), .file_wr_data_ff(file_wr_data_ff));
`default_nettype wire
